// >>> logic/deep_sleep_control_wake.sv
// Deep-sleep control, wake-up sources, retained context and module enables
//
// What this block does
// RL1 - Context registers store only after two writes
// RL2 - Context values survive battery-backup mode
// RL3 - Leaving battery-backup raises power-on reset
// RL4 - Oscillator pins hold state for RTC clock
// RL5 - Low control bits 7..2 read zero
// RL6 - Brownout flag set on brownout in sleep
// RL7 - Brownout in sleep never wakes device
// RL8 - Pins held until release bit cleared
// RL9 - Entry enable decides deep sleep on sleep
// RL10 - Entry enable needs two writes
// RL11 - High control bit 0 blocks RTC wake
// RL12 - Wake source registers need two writes
// RL13 - High wake bit 0 gates external irq
// RL14 - Module enable clear stops module, clock stays
// RL15 - Each timer has own on bit 7
// RL16 - Converter on bit acts as module enable
// RL17 - Ports and their features have no enable
// RL18 - Wake register bit 6 shows sleep brownout
// RL19 - Context kept on master clear, sleep brownout erases it only without backup power
// RL20 - Wake low register holds eight cause flags
// RL21 - Fault flag set on fault during sleep
//
// Strobed register access and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "deep_sleep_consts.svh"
module deep_sleep_control_wake
  import deep_sleep_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic sleep_instr,
  input wire logic brownout_enable,
  input wire logic brownout_pin,
  input wire logic external_irq_zero,
  input wire logic backup_mode_pin,
  input wire logic backup_powered_pin,
  input wire logic rtc_on_second_osc,
  input wire logic sleep_watchdog_wake,
  input wire logic rtc_alarm_wake,
  input wire logic master_clear,
  input wire logic debugger_wake,
  input wire logic fault_detect,
  output logic deep_sleep,
  output logic io_hold,
  output logic osc_pin_hold,
  output logic por_request,
  output logic module_run,
  output logic timer_run,
  output logic converter_run
);

  // ******************************************************
  // Input synchronisers
  // ******************************************************
  logic [4:0] sync1_r;
  logic [4:0] sync2_r;
  wire [4:0] pins_in = {rtc_on_second_osc, backup_powered_pin, backup_mode_pin, external_irq_zero, brownout_pin};

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++)
    begin : g_sync
      // No reset: backup supply level must stay visible during reset
      always_ff @(posedge clk_sys)
      begin
        sync1_r[gi] <= pins_in[gi];
        sync2_r[gi] <= sync1_r[gi];
      end
    end
  endgenerate

  wire bor_s = sync2_r[0];
  wire irq0_s = sync2_r[1];
  wire backup_s = sync2_r[2];
  wire powered_s = sync2_r[3];
  wire on_osc_s = sync2_r[4];
  wire ctx_erase;

  // ******************************************************
  // Twice-written registers
  // ******************************************************
  dw_if dw [`DW_COUNT] ();
  wire [3:0] dw_ofs [`DW_COUNT];
  wire [7:0] dw_mask [`DW_COUNT];

  generate
    for (gi = 0; gi < `DW_COUNT; gi++)
    begin : g_dw
      assign dw[gi].wr = reg_wr && (reg_addr == dw_ofs[gi]); // RL1 RL10 RL12
      assign dw[gi].wdata = reg_wdata & dw_mask[gi];
      dw_reg u_reg (
        .clk_sys(clk_sys),
        .srst(srst),
        .port(dw[gi])
      );
    end
    for (gi = 0; gi < `CONTEXT_COUNT; gi++)
    begin : g_ctx
      assign dw_ofs[`DW_CONTEXT_BASE + gi] = `OFS_CONTEXT_BASE + 4'(gi);
      assign dw_mask[`DW_CONTEXT_BASE + gi] = 8'hFF;
      assign dw[`DW_CONTEXT_BASE + gi].hw_set = `REG_RESET;
      assign dw[`DW_CONTEXT_BASE + gi].hw_clr = `REG_RESET;
      assign dw[`DW_CONTEXT_BASE + gi].keep_on_reset = powered_s; // RL2 RL3
      assign dw[`DW_CONTEXT_BASE + gi].erase = ctx_erase; // RL19
    end
  endgenerate

  assign dw_ofs[`DW_CTL_HIGH] = `OFS_CTL_HIGH;
  assign dw_ofs[`DW_WAKE_LOW] = `OFS_WAKE_LOW;
  assign dw_ofs[`DW_WAKE_HIGH] = `OFS_WAKE_HIGH;
  assign dw_mask[`DW_CTL_HIGH] = `CTL_HIGH_MASK;
  assign dw_mask[`DW_WAKE_LOW] = 8'hFF;
  assign dw_mask[`DW_WAKE_HIGH] = `WAKE_HIGH_MASK;

  wire [7:0] ctl_high = dw[`DW_CTL_HIGH].value;
  wire [7:0] wake_low = dw[`DW_WAKE_LOW].value;
  wire [7:0] wake_high = dw[`DW_WAKE_HIGH].value;
  wire [7:0] ctx0 = dw[`DW_CONTEXT_BASE].value;

  // ******************************************************
  // Wake and event decoding
  // ******************************************************
  sleep_state_t state_r;
  sleep_state_t state_nxt;
  logic backup_d_r;
  wire asleep = (state_r == ST_ASLEEP);
  wire bor_event = asleep && brownout_enable && bor_s;
  assign ctx_erase = bor_event && !powered_s; // RL19
  wire irq_wake = irq0_s && wake_high[`WAKE_HIGH_IRQ0]; // RL13
  wire rtc_wake = rtc_alarm_wake && !ctl_high[`CTL_HIGH_RTC_DIS]; // RL11
  // Brownout is left out on purpose: it records status and, without backup power, erases context
  wire wake = asleep && (irq_wake || rtc_wake || sleep_watchdog_wake || master_clear || debugger_wake); // RL7
  wire enter = !asleep && sleep_instr && ctl_high[`CTL_HIGH_ENTRY]; // RL9
  wire backup_exit = backup_d_r && !backup_s;

  wire [7:0] wake_set = {
    asleep && fault_detect, // RL21
    bor_event, // RL18
    wake && irq_wake,
    wake && sleep_watchdog_wake,
    wake && rtc_wake,
    wake && master_clear,
    wake && debugger_wake,
    backup_exit
  }; // RL20
  assign dw[`DW_WAKE_LOW].hw_set = wake_set;
  assign dw[`DW_WAKE_LOW].hw_clr = `REG_RESET;
  assign dw[`DW_WAKE_HIGH].hw_set = `REG_RESET;
  assign dw[`DW_WAKE_HIGH].hw_clr = `REG_RESET;
  // Fault during sleep locks out RTC wake until software re-arms it
  assign dw[`DW_CTL_HIGH].hw_set = {7'h00, asleep && fault_detect}; // RL11
  // Entry enable drops on wake so the next sleep is plain sleep
  assign dw[`DW_CTL_HIGH].hw_clr = {wake, 7'h00};
  generate
    for (gi = 0; gi < `DW_WAKE_HIGH + 1; gi++)
    begin : g_keep
      assign dw[gi].keep_on_reset = 1'b0;
      assign dw[gi].erase = 1'b0;
    end
  endgenerate

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      ST_AWAKE:
        if (enter)
          state_nxt = ST_ASLEEP; // RL9
      ST_ASLEEP:
        if (wake)
          state_nxt = ST_AWAKE;
    endcase
  end

  // ******************************************************
  // Low control register and outputs
  // ******************************************************
  logic [7:0] ctl_low_r;
  logic [7:0] ctl_low_nxt;
  logic [7:0] module_ctl_r;
  logic [7:0] timer_ctl_r;
  logic [7:0] converter_ctl_r;
  wire ctl_low_wr = reg_wr && (reg_addr == `OFS_CTL_LOW);
  wire release_set = wake && !master_clear; // RL8
  wire release_clr = (asleep && master_clear) || ctx_erase;

  always_comb
  begin
    ctl_low_nxt = ctl_low_wr ? (reg_wdata & `CTL_LOW_MASK) : ctl_low_r;
    if (release_clr)
      ctl_low_nxt[`CTL_LOW_RELEASE] = 1'b0;
    if (release_set)
      ctl_low_nxt[`CTL_LOW_RELEASE] = 1'b1; // RL8
    if (bor_event)
      ctl_low_nxt[`CTL_LOW_BROWNOUT] = 1'b1; // RL6
    ctl_low_nxt[7:2] = 6'h00; // RL5
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      state_r <= ST_AWAKE;
      ctl_low_r <= `REG_RESET;
      backup_d_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      ctl_low_r <= ctl_low_nxt;
      backup_d_r <= backup_s;
    end
  end

  // Ports, change notification and capture have no enable here
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      module_ctl_r <= `REG_RESET;
      timer_ctl_r <= `REG_RESET;
      converter_ctl_r <= `REG_RESET;
    end
    else
    begin
      if (reg_wr && reg_addr == `OFS_MODULE_CTL)
        module_ctl_r <= reg_wdata; // RL14
      if (reg_wr && reg_addr == `OFS_TIMER_CTL)
        timer_ctl_r <= reg_wdata; // RL15
      if (reg_wr && reg_addr == `OFS_CONVERTER_CTL)
        converter_ctl_r <= reg_wdata; // RL16
    end
  end // RL17

  wire [7:0] rd_mux =
    (reg_addr == `OFS_CTL_LOW) ? ctl_low_r :
    (reg_addr == `OFS_CTL_HIGH) ? ctl_high :
    (reg_addr == `OFS_WAKE_LOW) ? wake_low :
    (reg_addr == `OFS_WAKE_HIGH) ? wake_high :
    (reg_addr == `OFS_CONTEXT_BASE) ? ctx0 :
    (reg_addr == `OFS_CONTEXT_BASE + 4'h1) ? dw[`DW_CONTEXT_BASE + 1].value :
    (reg_addr == `OFS_CONTEXT_BASE + 4'h2) ? dw[`DW_CONTEXT_BASE + 2].value :
    (reg_addr == `OFS_CONTEXT_BASE + 4'h3) ? dw[`DW_CONTEXT_BASE + 3].value :
    (reg_addr == `OFS_MODULE_CTL) ? module_ctl_r :
    (reg_addr == `OFS_TIMER_CTL) ? timer_ctl_r :
    (reg_addr == `OFS_CONVERTER_CTL) ? converter_ctl_r : 8'h00;

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      reg_rdata <= 8'h00;
      deep_sleep <= 1'b0;
      io_hold <= 1'b0;
      osc_pin_hold <= 1'b0;
      por_request <= 1'b0;
      module_run <= 1'b0;
      timer_run <= 1'b0;
      converter_run <= 1'b0;
    end
    else
    begin
      reg_rdata <= reg_rd ? rd_mux : 8'h00; // RL2
      deep_sleep <= (state_nxt == ST_ASLEEP);
      io_hold <= (state_nxt == ST_ASLEEP) || ctl_low_nxt[`CTL_LOW_RELEASE]; // RL8
      osc_pin_hold <= backup_s && on_osc_s; // RL4
      por_request <= backup_exit; // RL3
      // Clock keeps running; only operation is gated
      module_run <= module_ctl_r[`ENABLE_BIT]; // RL14
      timer_run <= timer_ctl_r[`ENABLE_BIT]; // RL15
      converter_run <= converter_ctl_r[`ENABLE_BIT]; // RL16
    end
  end

  // ******************************************************
  // Assertions
  // ******************************************************
  entry_taken_a: assert property (@(posedge clk_sys) disable iff (srst)
    enter |=> deep_sleep) else $error("deep sleep not entered"); // RL9
  entry_blocked_a: assert property (@(posedge clk_sys) disable iff (srst)
    !asleep && sleep_instr && !ctl_high[`CTL_HIGH_ENTRY] |=> !deep_sleep) else $error("sleep without enable"); // RL9
  bor_no_wake_a: assert property (@(posedge clk_sys) disable iff (srst)
    bor_event && !wake |=> deep_sleep) else $error("brownout woke device"); // RL7
  bor_flags_a: assert property (@(posedge clk_sys) disable iff (srst)
    bor_event |=> ctl_low_r[`CTL_LOW_BROWNOUT] && wake_low[`WAKE_LOW_BROWNOUT]) else $error("brownout flag lost"); // RL6
  reserved_zero_a: assert property (@(posedge clk_sys) disable iff (srst)
    ctl_low_r[7:2] == 6'h00) else $error("reserved bits set"); // RL5
  pin_hold_a: assert property (@(posedge clk_sys) disable iff (srst)
    release_set && !ctl_low_wr |=> io_hold && ctl_low_r[`CTL_LOW_RELEASE])
    else $error("pins not held after wake"); // RL8
  irq_gate_a: assert property (@(posedge clk_sys) disable iff (srst)
    asleep && !wake_high[`WAKE_HIGH_IRQ0] && !rtc_wake && !sleep_watchdog_wake && !master_clear && !debugger_wake
    |=> deep_sleep) else $error("masked irq woke device"); // RL13
  rtc_gate_a: assert property (@(posedge clk_sys) disable iff (srst)
    asleep && ctl_high[`CTL_HIGH_RTC_DIS] && !irq_wake && !sleep_watchdog_wake && !master_clear && !debugger_wake
    |=> deep_sleep) else $error("disabled rtc woke device"); // RL11
  por_raise_a: assert property (@(posedge clk_sys) disable iff (srst)
    $fell(backup_s) |=> por_request && wake_low[`WAKE_LOW_POR]) else $error("no reset on backup exit"); // RL3
  ctx_keep_a: assert property (@(posedge clk_sys) disable iff (srst)
    asleep && master_clear && !ctx_erase && !reg_wr |=> $stable(ctx0)) else $error("context lost"); // RL19
  osc_hold_a: assert property (@(posedge clk_sys) disable iff (srst)
    backup_s && on_osc_s |=> osc_pin_hold) else $error("oscillator pins released"); // RL4
  enable_off_a: assert property (@(posedge clk_sys) disable iff (srst)
    reg_wr && reg_addr == `OFS_MODULE_CTL && !reg_wdata[`ENABLE_BIT] |=> ##1 !module_run)
    else $error("module still running"); // RL14

endmodule : deep_sleep_control_wake

// >>> logic/deep_sleep_consts.svh
// Register offsets, field positions and reset values of the deep-sleep control block
`ifndef DEEP_SLEEP_CONSTS_SVH
`define DEEP_SLEEP_CONSTS_SVH

`define OFS_CTL_LOW 4'h0
`define OFS_CTL_HIGH 4'h1
`define OFS_WAKE_LOW 4'h2
`define OFS_WAKE_HIGH 4'h3
`define OFS_CONTEXT_BASE 4'h4
`define OFS_MODULE_CTL 4'h8
`define OFS_TIMER_CTL 4'h9
`define OFS_CONVERTER_CTL 4'hA

`define CTL_LOW_RELEASE 0
`define CTL_LOW_BROWNOUT 1
`define CTL_LOW_MASK 8'h03
`define CTL_HIGH_ENTRY 7
`define CTL_HIGH_RTC_DIS 0
`define CTL_HIGH_MASK 8'h81

`define WAKE_LOW_FAULT 7
`define WAKE_LOW_BROWNOUT 6
`define WAKE_LOW_EXTERNAL 5
`define WAKE_LOW_WATCHDOG 4
`define WAKE_LOW_RTC 3
`define WAKE_LOW_MASTER_CLEAR 2
`define WAKE_LOW_DEBUGGER 1
`define WAKE_LOW_POR 0
`define WAKE_HIGH_IRQ0 0
`define WAKE_HIGH_MASK 8'h01

`define ENABLE_BIT 7
`define REG_RESET 8'h00
`define CONTEXT_COUNT 4
`define DW_COUNT 7
`define DW_CTL_HIGH 0
`define DW_WAKE_LOW 1
`define DW_WAKE_HIGH 2
`define DW_CONTEXT_BASE 3

`endif

// >>> logic/deep_sleep_pkg.sv
// Types shared by the deep-sleep control block
package deep_sleep_pkg;

  typedef enum logic [0:0] {
    ST_AWAKE = 1'b0,
    ST_ASLEEP = 1'b1
  } sleep_state_t;

  typedef logic [7:0] byte_t;

endpackage : deep_sleep_pkg

// >>> logic/dw_if.sv
// Carrier between the control block and one twice-written register
`timescale 1ns/1ps
interface dw_if;
  logic wr;
  logic [7:0] wdata;
  logic [7:0] hw_set;
  logic [7:0] hw_clr;
  logic keep_on_reset;
  logic erase;
  logic [7:0] value;

  modport owner (output wr, output wdata, output hw_set, output hw_clr, output keep_on_reset, output erase,
                 input value);
  modport store (input wr, input wdata, input hw_set, input hw_clr, input keep_on_reset, input erase,
                 output value);
endinterface : dw_if

// >>> logic/dw_reg.sv
// Register that takes a software value only on the second matching write
`timescale 1ns/1ps
`include "deep_sleep_consts.svh"
module dw_reg
  import deep_sleep_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  dw_if.store port
);

  logic armed_r;
  byte_t pend_r;
  byte_t value_r;
  wire commit = port.wr && armed_r && (port.wdata == pend_r);
  wire [7:0] sw_value = commit ? port.wdata : value_r;
  // Hardware set wins over a clear or a commit in the same cycle
  wire [7:0] value_nxt = (sw_value & ~port.hw_clr) | port.hw_set;

  assign port.value = value_r;

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      armed_r <= 1'b0;
      pend_r <= `REG_RESET;
    end
    else if (port.wr)
    begin
      armed_r <= !commit;
      pend_r <= port.wdata;
    end
  end

  // Retained contents survive reset while the backup supply holds them
  always_ff @(posedge clk_sys)
  begin
    if ((srst && !port.keep_on_reset) || port.erase)
      value_r <= `REG_RESET;
    else if (!srst)
      value_r <= value_nxt;
  end

endmodule : dw_reg

// >>> verif/deep_sleep_control_wake_bench.sv
// Self-checking bench for the deep-sleep control block
`timescale 1ns/1ps
`include "deep_sleep_consts.svh"
module deep_sleep_control_wake_bench
  import deep_sleep_pkg::*;
;
  // ****************************************
  // Stimulus and observed signals
  // ****************************************
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  byte_t reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  byte_t reg_rdata;
  logic sleep_instr = 1'b0;
  logic brownout_enable = 1'b0;
  logic brownout_pin = 1'b0;
  logic external_irq_zero = 1'b0;
  logic backup_mode_pin = 1'b0;
  logic backup_powered_pin = 1'b0;
  logic rtc_on_second_osc = 1'b0;
  logic sleep_watchdog_wake = 1'b0;
  logic rtc_alarm_wake = 1'b0;
  logic master_clear = 1'b0;
  logic debugger_wake = 1'b0;
  logic fault_detect = 1'b0;
  logic deep_sleep, io_hold, osc_pin_hold, por_request, module_run, timer_run, converter_run;
  int n_mismatch = 0;
  int cmp_count = 0;
  int por_seen = 0;
  byte_t d;

  deep_sleep_control_wake i_deep_sleep_control_wake (.clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_instr(sleep_instr),
    .brownout_enable(brownout_enable), .brownout_pin(brownout_pin), .external_irq_zero(external_irq_zero),
    .backup_mode_pin(backup_mode_pin), .backup_powered_pin(backup_powered_pin),
    .rtc_on_second_osc(rtc_on_second_osc), .sleep_watchdog_wake(sleep_watchdog_wake),
    .rtc_alarm_wake(rtc_alarm_wake), .master_clear(master_clear), .debugger_wake(debugger_wake),
    .fault_detect(fault_detect), .deep_sleep(deep_sleep), .io_hold(io_hold), .osc_pin_hold(osc_pin_hold),
    .por_request(por_request), .module_run(module_run), .timer_run(timer_run), .converter_run(converter_run));

  initial
  begin
    forever #25 clk_sys = ~clk_sys;
  end

  // Pulse is only one cycle wide, so count it at every edge
  always @(posedge clk_sys)
  begin
    if (por_request === 1'b1)
      por_seen <= por_seen + 1;
  end

  // ****************************************
  // Bus and check tasks
  // ****************************************
  task automatic chk(input byte_t got, input byte_t exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input byte_t v);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic wr2(input logic [3:0] a, input byte_t v);
    wr(a, v);
    wr(a, v);
  endtask : wr2

  task automatic rd(input logic [3:0] a, output byte_t v);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
    v = reg_rdata;
  endtask : rd

  task automatic go_sleep();
    @(posedge clk_sys);
    sleep_instr <= 1'b1;
    @(posedge clk_sys);
    sleep_instr <= 1'b0;
    @(posedge clk_sys);
  endtask : go_sleep

  // Bounded wait, the external irq wake path runs through pin synchronisers
  task automatic wait_sleep(input logic exp);
    for (int i = 0; i < 12 && deep_sleep !== exp; i++)
      @(posedge clk_sys);
    chk({7'h0, deep_sleep}, {7'h0, exp}, "sleep state");
  endtask : wait_sleep

  task automatic give_verdict();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    for (int a = 0; a < 12; a++)
    begin
      rd(a[3:0], d);
      chk(d, `REG_RESET, "reset value");
    end
  endtask : t_reset

  task automatic t_double();
    backup_powered_pin <= 1'b1;
    for (int a = 4; a < 8; a++)
    begin
      wr(a[3:0], 8'hA0 + a[7:0]);
      rd(a[3:0], d);
      chk(d, 8'h00, "context after one write");
      wr(a[3:0], 8'hA0 + a[7:0]);
      rd(a[3:0], d);
      chk(d, 8'hA0 + a[7:0], "context after two writes");
    end
    wr(`OFS_CONTEXT_BASE, 8'h5A);
    wr(`OFS_CONTEXT_BASE + 4'h1, 8'h33);
    wr(`OFS_CONTEXT_BASE, 8'h5A);
    rd(`OFS_CONTEXT_BASE, d);
    chk(d, 8'h5A, "context armed across other write");
    wr(`OFS_WAKE_HIGH, 8'hFF);
    rd(`OFS_WAKE_HIGH, d);
    chk(d, 8'h00, "wake high after one write");
    wr2(`OFS_WAKE_HIGH, 8'hFF);
    rd(`OFS_WAKE_HIGH, d);
    chk(d, 8'h01, "wake high mask");
  endtask : t_double

  task automatic t_entry();
    go_sleep();
    chk({7'h0, deep_sleep}, 8'h00, "sleep without enable");
    wr(`OFS_CTL_HIGH, 8'h80);
    rd(`OFS_CTL_HIGH, d);
    chk(d, 8'h00, "entry enable after one write");
    go_sleep();
    chk({7'h0, deep_sleep}, 8'h00, "sleep with half-written enable");
    wr(`OFS_CTL_HIGH, 8'h80);
    rd(`OFS_CTL_HIGH, d);
    chk(d, 8'h80, "entry enable after two writes");
    go_sleep();
    chk({6'h0, deep_sleep, io_hold}, 8'h03, "asleep and pins held");
  endtask : t_entry

  task automatic t_brownout_wake();
    brownout_enable <= 1'b1;
    brownout_pin <= 1'b1;
    repeat (6) @(posedge clk_sys);
    brownout_pin <= 1'b0;
    chk({7'h0, deep_sleep}, 8'h01, "brownout keeps sleep");
    rd(`OFS_CTL_LOW, d);
    chk(d & 8'h02, 8'h02, "brownout flag");
    rd(`OFS_WAKE_LOW, d);
    chk(d & 8'h40, 8'h40, "wake brownout flag");
    external_irq_zero <= 1'b1;
    wait_sleep(1'b0);
    external_irq_zero <= 1'b0;
    chk({7'h0, io_hold}, 8'h01, "pins held after wake");
    rd(`OFS_CTL_LOW, d);
    chk(d & 8'h01, 8'h01, "release bit after wake");
    rd(`OFS_WAKE_LOW, d);
    chk(d & 8'h20, 8'h20, "external wake flag");
    wr(`OFS_CTL_LOW, 8'hFF);
    rd(`OFS_CTL_LOW, d);
    chk(d, 8'h03, "low control unused bits");
    wr(`OFS_CTL_LOW, 8'h00);
    @(posedge clk_sys);
    chk({7'h0, io_hold}, 8'h00, "pins released");
  endtask : t_brownout_wake

  task automatic t_fault_rtc();
    wr2(`OFS_CTL_HIGH, 8'h80);
    go_sleep();
    @(posedge clk_sys);
    fault_detect <= 1'b1;
    @(posedge clk_sys);
    fault_detect <= 1'b0;
    rd(`OFS_CTL_HIGH, d);
    chk(d, 8'h81, "rtc disable set by fault");
    rd(`OFS_WAKE_LOW, d);
    chk(d & 8'h80, 8'h80, "fault flag");
    rtc_alarm_wake <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rtc_alarm_wake <= 1'b0;
    chk({7'h0, deep_sleep}, 8'h01, "rtc wake blocked");
    master_clear <= 1'b1;
    wait_sleep(1'b0);
    master_clear <= 1'b0;
    rd(`OFS_CTL_LOW, d);
    chk(d & 8'h01, 8'h00, "master clear releases pins");
    rd(`OFS_WAKE_LOW, d);
    chk(d & 8'h04, 8'h04, "master clear flag");
    wr2(`OFS_CTL_HIGH, 8'h80);
    go_sleep();
    rtc_alarm_wake <= 1'b1;
    wait_sleep(1'b0);
    rtc_alarm_wake <= 1'b0;
    wr2(`OFS_CTL_HIGH, 8'h80);
    go_sleep();
    sleep_watchdog_wake <= 1'b1;
    wait_sleep(1'b0);
    sleep_watchdog_wake <= 1'b0;
    wr2(`OFS_CTL_HIGH, 8'h80);
    go_sleep();
    debugger_wake <= 1'b1;
    wait_sleep(1'b0);
    debugger_wake <= 1'b0;
    rd(`OFS_WAKE_LOW, d);
    chk(d & 8'h1A, 8'h1A, "watchdog rtc debugger flags");
  endtask : t_fault_rtc

  task automatic t_backup();
    backup_mode_pin <= 1'b1;
    repeat (5) @(posedge clk_sys);
    chk({7'h0, osc_pin_hold}, 8'h00, "osc pins free without rtc osc");
    rtc_on_second_osc <= 1'b1;
    repeat (5) @(posedge clk_sys);
    chk({7'h0, osc_pin_hold}, 8'h01, "osc pins held");
    backup_mode_pin <= 1'b0;
    repeat (6) @(posedge clk_sys);
    chk(por_seen[7:0], 8'h01, "power-on request pulse");
    rd(`OFS_WAKE_LOW, d);
    chk(d & 8'h01, 8'h01, "power-on flag");
    srst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    rd(`OFS_CONTEXT_BASE, d);
    chk(d, 8'h5A, "context kept across reset");
    backup_powered_pin <= 1'b0;
    repeat (3) @(posedge clk_sys);
    srst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    rd(`OFS_CONTEXT_BASE, d);
    chk(d, 8'h00, "context lost without backup");
  endtask : t_backup

  task automatic t_enable();
    for (int i = 0; i < 3; i++)
    begin
      wr(`OFS_MODULE_CTL + i[3:0], 8'h80);
      repeat (2) @(posedge clk_sys);
      chk({5'h0, module_run, timer_run, converter_run}, 8'h04 >> i, "enable on");
      wr(`OFS_MODULE_CTL + i[3:0], 8'h7F);
      repeat (2) @(posedge clk_sys);
      chk({5'h0, module_run, timer_run, converter_run}, 8'h00, "enable off");
    end
  endtask : t_enable

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial
  begin
    repeat (8) @(posedge clk_sys);
    srst <= 1'b0;
    t_reset();
    t_double();
    t_entry();
    t_brownout_wake();
    t_fault_rtc();
    t_backup();
    t_enable();
    give_verdict();
  end

  initial
  begin
    repeat (4000) @(posedge clk_sys);
    n_mismatch++;
    $display("unexpected at %0t: run did not finish", $time);
    give_verdict();
  end
endmodule : deep_sleep_control_wake_bench
